/* File: pkg/fetch_pc_regs.svh */
`ifndef FETCH_PC_REGS_SVH
`define FETCH_PC_REGS_SVH

// Register byte offsets on the APB slave
`define PC_LOW_OFFSET      12'h000
`define PC_FULL_OFFSET     12'h004
`define FETCH_CTRL_OFFSET  12'h008
`define FETCH_STAT_OFFSET  12'h00c

// Field positions
`define CTRL_RUN_BIT       0
`define STAT_STALL_BIT     0
`define STAT_PHASE_LSB     1

// Reset values
`define PC_RESET_VALUE     14'h0000
`define CTRL_RESET_VALUE   32'h00000001

// Phases per instruction cycle
`define PHASES_PER_CYCLE   4

`endif

/* File: pkg/fetch_pc_pkg.sv */
package fetch_pc_pkg;

  // Phase sequence, Gray coded along T1..T4
  typedef enum logic [1:0]
  {
    PH_ONE   = 2'b00,
    PH_TWO   = 2'b01,
    PH_THREE = 2'b11,
    PH_FOUR  = 2'b10
  } phase_e;

  // Flow operation reported by the executing instruction at phase four
  typedef enum logic [2:0]
  {
    FLOW_NEXT   = 3'h0,
    FLOW_JUMP   = 3'h1,
    FLOW_CALL   = 3'h2,
    FLOW_RETURN = 3'h3,
    FLOW_SKIP   = 3'h4,
    FLOW_INTR   = 3'h5
  } flow_e;

endpackage

/* File: src/instruction_fetch_pc_pipeline.sv */
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "fetch_pc_regs.svh"
// Contract
// [RL1] System clock split into four non-overlapping phases; four phases make one cycle.
// [RL2] Counter increments at phase one start; next word fetched in that phase; the code increments at phase one end, after fetching at the old value.
// [RL3] Phases two to four decode and execute the previously fetched word.
// [RL4] Fetch overlaps execution, giving one instruction per cycle when flow is linear; the code fetches in phase one and executes in phases two to four.
// [RL5] Jump, call and other counter changes take two instruction cycles.
// [RL6] Linear instructions advance the counter by exactly one.
// [RL7] Jump, call, interrupt or reset load the target directly into the counter.
// [RL8] Taken skip discards the prefetched word and runs a dummy cycle.
// [RL9] Only the low counter byte is software visible, readable and writable; the code also reads the full counter at PC_FULL_OFFSET.
// [RL10] Low byte write jumps within the current 256-word page.
// [RL11] A low byte write inserts a dummy cycle to prefetch the new word.
// [RL12] Call or interrupt pushes the counter; return restores it from the stack.
// [RL13] Any reset sets the counter to zero and fetch starts there.
// [RL14] Counter width is a parameter of 10 to 14 bits; upper bits not writable.
module instruction_fetch_pc_pipeline
  import fetch_pc_pkg::*;
#(
  parameter int PC_WIDTH     = 14,
  parameter int STACK_DEPTH  = 8,
  parameter int INSTR_WIDTH  = 16
)
(
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Program memory
  output logic      [PC_WIDTH-1:0]    pmem_addr,
  output logic                        pmem_rd,
  input  wire logic [INSTR_WIDTH-1:0] pmem_data,
  // Execution unit
  output logic      [INSTR_WIDTH-1:0] exec_instr,
  output logic                        exec_valid,
  input  wire logic [2:0]             exec_flow,
  input  wire logic [PC_WIDTH-1:0]    exec_target,
  input  wire logic                   exec_skip_taken,
  // Phase clocks and stack overflow flag
  output logic                        phase_one_clock,
  output logic                        phase_two_clock,
  output logic                        phase_three_clock,
  output logic                        phase_four_clock,
  output logic                        stack_overflow
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  phase_e                  phase_reg;
  phase_e                  phase_next;
  logic [PC_WIDTH-1:0]     pc_reg;
  logic [PC_WIDTH-1:0]     pc_next;
  logic [INSTR_WIDTH-1:0]  ir_reg;
  logic                    ir_valid_reg;
  logic                    dummy_reg;
  logic                    branch_pend_reg;
  logic [PC_WIDTH-1:0]     branch_tgt_reg;
  logic                    run_reg;
  logic                    pcl_wr_pend_reg;
  logic [7:0]              pcl_wr_val_reg;
  logic [PC_WIDTH-1:0]     stack_mem [STACK_DEPTH];
  logic [SP_W-1:0]         sp_reg;
  logic [SP_W:0]           depth_reg;
  logic                    ovf_reg;
  logic                    wr_en;
  logic                    rd_en;
  logic                    at_phase_four;
  flow_e                   flow;
  logic                    push;
  logic                    pop;
  logic                    load_pc;
  logic [PC_WIDTH-1:0]     load_val;

  // Read data is loaded in the setup cycle so that it already stands
  // at the access edge, where the master takes it with zero wait states
  assign wr_en         = psel && penable && pwrite;
  assign rd_en         = psel && !penable && !pwrite;
  assign pready        = 1'b1;
  assign pslverr       = 1'b0;
  assign at_phase_four = run_reg && (phase_reg == PH_FOUR);
  assign flow          = flow_e'(exec_flow);

  // Phase sequencer; halts at phase one while stopped
  always_comb
  begin
    case (phase_reg)
      PH_ONE:   phase_next = run_reg ? PH_TWO : PH_ONE; // RL1
      PH_TWO:   phase_next = PH_THREE;
      PH_THREE: phase_next = PH_FOUR;
      PH_FOUR:  phase_next = PH_ONE;
      default:  phase_next = PH_ONE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_reg <= PH_ONE;
    else
      phase_reg <= phase_next; // RL1
  end

  // One-hot phase outputs cannot overlap by construction
  assign phase_one_clock   = run_reg && (phase_reg == PH_ONE); // RL1
  assign phase_two_clock   = run_reg && (phase_reg == PH_TWO); // RL3
  assign phase_three_clock = run_reg && (phase_reg == PH_THREE); // RL3
  assign phase_four_clock  = at_phase_four; // RL3

  // Instruction word is fetched during phase one at the counter value
  assign pmem_addr = pc_reg; // RL2
  assign pmem_rd   = phase_one_clock; // RL2

  // Latching the word at phase one end holds it for execution in phases two to four
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ir_reg       <= '0;
      ir_valid_reg <= 1'b0;
    end
    else if (phase_one_clock)
    begin
      ir_reg       <= pmem_data; // RL4
      ir_valid_reg <= !dummy_reg && !branch_pend_reg; // RL8
    end
  end

  // Executed word is valid across phases two to four
  assign exec_instr = ir_reg; // RL3
  assign exec_valid = ir_valid_reg && !phase_one_clock; // RL3

  // Stack push and pop on flow events
  assign push = at_phase_four && ir_valid_reg && !branch_pend_reg
                && (flow == FLOW_CALL || flow == FLOW_INTR); // RL12
  assign pop  = at_phase_four && ir_valid_reg && !branch_pend_reg
                && (flow == FLOW_RETURN); // RL12

  // Counter next value: branch completes in the second cycle of the instruction
  always_comb
  begin
    load_pc  = 1'b0;
    load_val = pc_reg;
    if (branch_pend_reg && at_phase_four)
    begin
      load_pc  = 1'b1;
      load_val = branch_tgt_reg; // RL5
    end
    pc_next = load_pc ? load_val : pc_reg;
    if (phase_one_clock)
      pc_next = pc_reg + PC_WIDTH'(1); // RL6
  end

  // Pending branch: first cycle captures the target, the next cycle executes it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      branch_pend_reg <= 1'b0;
      branch_tgt_reg  <= '0;
    end
    else if (at_phase_four)
    begin
      branch_pend_reg <= 1'b0;
      if (!branch_pend_reg && pcl_wr_pend_reg)
      begin
        branch_pend_reg <= 1'b1; // RL11
        branch_tgt_reg  <= {pc_reg[PC_WIDTH-1:8], pcl_wr_val_reg}; // RL10
      end
      else if (!branch_pend_reg && ir_valid_reg)
      begin
        case (flow)
          FLOW_JUMP, FLOW_CALL, FLOW_INTR:
          begin
            branch_pend_reg <= 1'b1; // RL5
            branch_tgt_reg  <= exec_target; // RL7
          end
          FLOW_RETURN:
          begin
            branch_pend_reg <= 1'b1; // RL12
            branch_tgt_reg  <= stack_mem[sp_reg - SP_W'(1)]; // RL12
          end
          default:
          begin
            branch_pend_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_reg <= `PC_RESET_VALUE; // RL13
    else
      pc_reg <= pc_next; // RL7
  end

  // Taken skip discards the prefetched word; branch_pend_reg covers the branch bubble
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dummy_reg <= 1'b0;
    else if (at_phase_four)
      dummy_reg <= ir_valid_reg && !branch_pend_reg
                   && flow == FLOW_SKIP && exec_skip_taken; // RL8
    else if (phase_one_clock)
      dummy_reg <= dummy_reg;
  end

  // Return address pushed is the already-incremented counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_reg    <= '0;
      depth_reg <= '0;
      ovf_reg   <= 1'b0;
    end
    else if (push)
    begin
      sp_reg <= (sp_reg == SP_W'(STACK_DEPTH - 1)) ? '0 : sp_reg + SP_W'(1); // RL12
      if (depth_reg == (SP_W+1)'(STACK_DEPTH))
        ovf_reg <= 1'b1;
      else
        depth_reg <= depth_reg + (SP_W+1)'(1);
    end
    else if (pop)
    begin
      sp_reg <= (sp_reg == '0) ? SP_W'(STACK_DEPTH - 1) : sp_reg - SP_W'(1); // RL12
      if (depth_reg != '0)
        depth_reg <= depth_reg - (SP_W+1)'(1);
    end
  end

  // Overflow overwrites the oldest entry by wrapping the pointer
  always_ff @(posedge pclk)
  begin
    if (push)
      stack_mem[sp_reg] <= pc_reg; // RL12
  end

  assign stack_overflow = ovf_reg;

  // Software writes to the low byte are held until the end of the first cycle with no branch pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pcl_wr_pend_reg <= 1'b0;
      pcl_wr_val_reg  <= '0;
    end
    else if (wr_en && paddr == `PC_LOW_OFFSET)
    begin
      pcl_wr_pend_reg <= 1'b1; // RL9
      pcl_wr_val_reg  <= pwdata[7:0]; // RL10
    end
    else if (at_phase_four && !branch_pend_reg)
      pcl_wr_pend_reg <= 1'b0; // RL11
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_reg <= 1'(`CTRL_RESET_VALUE >> `CTRL_RUN_BIT);
    else if (wr_en && paddr == `FETCH_CTRL_OFFSET)
      run_reg <= pwdata[`CTRL_RUN_BIT];
  end

  // Read data registered; full counter readable but upper bits never writable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd_en)
    begin
      case (paddr)
        `PC_LOW_OFFSET:     prdata <= {24'h000000, pc_reg[7:0]}; // RL9
        `PC_FULL_OFFSET:    prdata <= 32'(pc_reg); // RL14
        `FETCH_CTRL_OFFSET: prdata <= {31'h00000000, run_reg};
        `FETCH_STAT_OFFSET: prdata <= {28'h0000000, ovf_reg, phase_reg, branch_pend_reg};
        default:            prdata <= '0;
      endcase
    end
  end

endmodule

/* File: sim/fetch_pc_checker_assertions.sv */
`timescale 1ns/1ns
module fetch_pc_checker
  import fetch_pc_pkg::*;
#(
  parameter int PC_WIDTH = 14
)
(
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // Program memory
  input wire logic [PC_WIDTH-1:0] pmem_addr,
  input wire logic                pmem_rd,
  // Execution unit
  input wire logic                exec_valid,
  input wire logic [2:0]          exec_flow,
  input wire logic [PC_WIDTH-1:0] exec_target,
  input wire logic                exec_skip_taken,
  // Phase clocks
  input wire logic                phase_one_clock,
  input wire logic                phase_two_clock,
  input wire logic                phase_three_clock,
  input wire logic                phase_four_clock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rest_of_cycle;
    phase_two_clock ##1 phase_three_clock ##1 phase_four_clock ##1 phase_one_clock;
  endsequence
  sequence s_discarded;
    phase_one_clock ##1 !exec_valid [*3];
  endsequence
  property p_phase_order;
    phase_one_clock |=> s_rest_of_cycle;
  endproperty
  property p_phase_onehot;
    $onehot({phase_one_clock, phase_two_clock, phase_three_clock, phase_four_clock});
  endproperty
  property p_fetch;
    phase_one_clock |-> pmem_rd;
  endproperty
  property p_increment;
    phase_one_clock |=> pmem_addr == PC_WIDTH'($past(pmem_addr) + 1);
  endproperty
  property p_hold;
    phase_two_clock |=> $stable(pmem_addr) [*2];
  endproperty
  property p_exec_window;
    exec_valid |-> !phase_one_clock;
  endproperty
  property p_reset_vector;
    $rose(presetn) |-> pmem_addr == '0 && phase_one_clock;
  endproperty
  property p_skip;
    phase_four_clock && exec_flow == FLOW_SKIP && exec_skip_taken |=> s_discarded;
  endproperty
  property p_branch;
    phase_four_clock && exec_flow inside {FLOW_JUMP, FLOW_CALL, FLOW_INTR}
      |-> ##5 phase_one_clock && pmem_addr == $past(exec_target, 5);
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order");
  a_phase_onehot: assert property (p_phase_onehot) else $error("phases overlap");
  a_fetch: assert property (p_fetch) else $error("no fetch in phase one");
  a_increment: assert property (p_increment) else $error("no increment");
  a_hold: assert property (p_hold) else $error("counter moved mid cycle");
  a_exec_window: assert property (p_exec_window) else $error("exec in phase one");
  a_reset_vector: assert property (p_reset_vector) else $error("reset vector");
  a_skip: assert property (p_skip) else $error("skip not discarded");
  a_branch: assert property (p_branch) else $error("branch target");
endmodule

bind instruction_fetch_pc_pipeline fetch_pc_checker #(.PC_WIDTH(PC_WIDTH)) u_fetch_pc_checker (
  .pclk(pclk), .presetn(presetn), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
  .exec_valid(exec_valid), .exec_flow(exec_flow), .exec_target(exec_target),
  .exec_skip_taken(exec_skip_taken), .phase_one_clock(phase_one_clock),
  .phase_two_clock(phase_two_clock), .phase_three_clock(phase_three_clock),
  .phase_four_clock(phase_four_clock));

/* File: sim/prog_memory_model.sv */
`timescale 1ns/1ns
module prog_memory_model
#(
  parameter int PC_WIDTH    = 14,
  parameter int INSTR_WIDTH = 16
)
(
  // Fetch port
  input  wire logic [PC_WIDTH-1:0]    pmem_addr,
  input  wire logic                   pmem_rd,
  output logic      [INSTR_WIDTH-1:0] pmem_data
);
  // Word follows the address so the bench can predict it; off a fetch the
  // bus shows the inverse, so a stale sample never looks right
  always_comb
  begin
    pmem_data = INSTR_WIDTH'(16'h5a00) ^ INSTR_WIDTH'(pmem_addr);
    if (!pmem_rd)
    begin
      pmem_data = ~pmem_data;
    end
  end
endmodule

/* File: sim/instruction_fetch_pc_pipeline_test.sv */
`timescale 1ns/1ns
`include "fetch_pc_regs.svh"
module instruction_fetch_pc_pipeline_test
  import fetch_pc_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, pmem_rd, exec_valid, exec_skip_taken = 1'b0, stack_overflow;
  logic [13:0] pmem_addr, exec_target = '0, saved, snap, ret;
  logic [15:0] pmem_data, exec_instr;
  logic [2:0]  exec_flow = FLOW_NEXT;
  logic        phase_one_clock, phase_two_clock, phase_three_clock, phase_four_clock;
  int          miscompares = 0, n_checks = 0, cnt;
`define CHECK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
  always #5 pclk = ~pclk;
  instruction_fetch_pc_pipeline #(.PC_WIDTH(14), .STACK_DEPTH(2), .INSTR_WIDTH(16))
    u_instruction_fetch_pc_pipeline (.*);
  prog_memory_model #(.PC_WIDTH(14), .INSTR_WIDTH(16)) u_prog_memory_model (.*);
  task conclude;
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wait_phase(input logic [3:0] ph);
    int n;
    n = 0;
    @(posedge pclk);
    while ({phase_one_clock, phase_two_clock, phase_three_clock, phase_four_clock} !== ph
           && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 40)
    begin
      miscompares++;
      conclude();
    end
  endtask
  // Read data is taken at the edge where pready is seen high; the wait stays bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    snap = pmem_addr;
    rd = prdata;
    if (n == 20)
    begin
      miscompares++;
      conclude();
    end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Drives a flow code during phase four only
  task automatic issue(input logic [2:0] f, input logic [13:0] tgt, input logic skip);
    wait_phase(4'b0010);
    exec_flow <= f; exec_target <= tgt; exec_skip_taken <= skip;
    @(posedge pclk);
    saved = pmem_addr;
    exec_flow <= FLOW_NEXT; exec_skip_taken <= 1'b0;
  endtask
  task automatic expect_fetch(input logic [13:0] exp);
    logic hit;
    hit = 1'b0;
    repeat (20)
    begin
      @(posedge pclk);
      if (phase_one_clock === 1'b1 && pmem_rd === 1'b1 && pmem_addr === exp) hit = 1'b1;
    end
    `CHECK(hit, 1'b1)
  endtask
  task t_reset;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHECK(pmem_addr, 14'h0000)
    `CHECK(phase_one_clock, 1'b1)
    apb(1'b0, `PC_LOW_OFFSET, 32'h0);
    `CHECK(rd, 32'h00000001)
    apb(1'b0, `FETCH_CTRL_OFFSET, 32'h0);
    `CHECK(rd, `CTRL_RESET_VALUE)
    apb(1'b0, 12'h010, 32'h0);
    `CHECK(rd, 32'h00000000)
    apb(1'b0, `PC_FULL_OFFSET, 32'h0);
    `CHECK(rd, 32'h00000004)
  endtask
  task t_linear;
    repeat (3)
    begin
      wait_phase(4'b0100);
      `CHECK(exec_instr, 16'h5a00 ^ {2'b00, pmem_addr - 14'h1})
      `CHECK(exec_valid, 1'b1)
      saved = pmem_addr;
      wait_phase(4'b0100);
      `CHECK(pmem_addr, saved + 14'h1)
    end
  endtask
  task t_flow;
    issue(FLOW_JUMP, 14'h1234, 1'b0);
    expect_fetch(14'h1234);
    issue(FLOW_CALL, 14'h0200, 1'b0);
    ret = saved;
    expect_fetch(14'h0200);
    issue(FLOW_RETURN, 14'h0000, 1'b0);
    expect_fetch(ret);
    issue(FLOW_INTR, 14'h0008, 1'b0);
    expect_fetch(14'h0008);
    repeat (2)
    begin
      issue(FLOW_CALL, 14'h0300, 1'b0);
      expect_fetch(14'h0300);
    end
    `CHECK(stack_overflow, 1'b1)
  endtask
  task t_skip;
    for (int tk = 0; tk < 2; tk++)
    begin
      issue(FLOW_SKIP, 14'h0000, tk[0]);
      cnt = 0;
      repeat (8)
      begin
        @(posedge pclk);
        cnt += int'(exec_valid === 1'b1);
      end
      `CHECK(cnt, (tk == 1) ? 3 : 6)
    end
  endtask
  // Upper write bits must be dropped and the page kept
  task t_low_write;
    issue(FLOW_JUMP, 14'h2f80, 1'b0);
    expect_fetch(14'h2f80);
    apb(1'b1, `PC_LOW_OFFSET, 32'hffffff40);
    expect_fetch(14'h2f40);
  endtask
  initial
  begin
    t_reset();
    t_linear();
    t_flow();
    t_skip();
    t_low_write();
    conclude();
  end
endmodule
